// ### verilog/rom_flash_pkg.sv
// Purpose: shared constants for the two-block ROM/Flash interface
// Assumes: 250 MHz system clock, processor byte addresses, big-endian lanes
// Notes:   base fields hold address bits 31:22; size code n means 1 MB << n
package rom_flash_pkg;

  localparam int          BASE_W       = 10;
  localparam int          BASE_LSB     = 22;
  localparam logic [9:0]  BASE_A_RST   = 10'h3fc;   // FF000000
  localparam logic [9:0]  BASE_B_RST   = 10'h3fd;   // FF400000
  localparam logic [11:0] ALIAS_TAG    = 12'hfff;   // FFF00000 window
  localparam int          ALIAS_LSB    = 20;
  localparam logic [2:0]  SIZE_RST     = 3'h0;      // 1 MB
  localparam logic [2:0]  SIZE_MAX     = 3'h6;      // 64 MB
  localparam logic [31:0] SIZE_UNIT    = 32'h0010_0000;
  localparam logic [3:0]  ACCESS_RST   = 4'hf;
  localparam logic [4:0]  SYNC_LAT     = 5'h2;      // pin synchroniser depth
  localparam logic [1:0]  STRAP_WAIT   = 2'h2;
  localparam logic [5:0]  BURST_BYTES  = 6'h20;
  localparam logic [31:0] BURST_MASK   = 32'hffff_ffe0;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_ACCESS = 3'b010,
    ST_GAP    = 3'b100
  } seq_state_t;

endpackage : rom_flash_pkg

// ### verilog/rom_block_cfg.sv
// Purpose: configuration, strap capture and address decode of one block
// Assumes: straps are board pins, stable around reset release
// Notes:   straps are sampled once, on the third edge (STRAP_WAIT + 1) after reset release
`timescale 1ns/1ps
module rom_block_cfg
  import rom_flash_pkg::*;
#(
  parameter logic [9:0] BASE_RST = BASE_A_RST
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        strapVec,
  input  wire logic        strapWide,
  input  wire logic        cfgWrite,
  input  wire logic        cfgEnableIn,
  input  wire logic        cfgWrEnIn,
  input  wire logic        cfgVecEnIn,
  input  wire logic [9:0]  cfgBaseIn,
  input  wire logic [2:0]  cfgSizeIn,
  input  wire logic [3:0]  cfgAccessIn,
  input  wire logic [31:0] reqAddr,
  output logic             enable_q,
  output logic             wrEn_q,
  output logic             vecEn_q,
  output logic             wide_q,
  output logic [9:0]       base_q,
  output logic [2:0]       size_q,
  output logic [3:0]       access_q,
  output logic             strapDone_q,
  output logic             hit,
  output logic             aliasHit,
  output logic [25:0]      offset
);

  logic [1:0]  sync1_q;
  logic [1:0]  sync2_q;
  logic [1:0]  wait_q;
  logic [31:0] diff;
  logic [31:0] span;
  logic        normalHit;

  // two-flop synchroniser for the straps
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_q <= 2'h0;
      sync2_q <= 2'h0;
    end
    else
    begin
      sync1_q <= {strapVec, strapWide};
      sync2_q <= sync1_q;
    end
  end

  // settle counter so straps are caught after release, not under reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wait_q      <= 2'h0;
      strapDone_q <= 1'b0;
    end
    else if (!strapDone_q)
    begin
      wait_q      <= wait_q + 2'h1;
      strapDone_q <= (wait_q == STRAP_WAIT);
    end
  end

  // software fields; width is strap only
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      enable_q <= 1'b0;
      wrEn_q   <= 1'b0;
      vecEn_q  <= 1'b0;
      wide_q   <= 1'b0;
      base_q   <= BASE_RST;
      size_q   <= SIZE_RST;
      access_q <= ACCESS_RST;
    end
    else if (!strapDone_q)
    begin
      if (wait_q == STRAP_WAIT)
      begin
        vecEn_q <= sync2_q[1];
        wide_q  <= sync2_q[0];
      end
    end
    else if (cfgWrite)
    begin
      enable_q <= cfgEnableIn;
      wrEn_q   <= cfgWrEnIn;
      vecEn_q  <= cfgVecEnIn;
      base_q   <= cfgBaseIn;
      size_q   <= (cfgSizeIn > SIZE_MAX) ? SIZE_MAX : cfgSizeIn;
      access_q <= cfgAccessIn;
    end
  end

  // window decode; the alias window takes precedence over the base window
  assign diff      = reqAddr - {base_q, 22'h0};
  assign span      = SIZE_UNIT << size_q;
  assign normalHit = enable_q && (diff < span);
  assign aliasHit  = vecEn_q &&
                     (reqAddr[31:ALIAS_LSB] == ALIAS_TAG);
  assign hit       = normalHit || aliasHit;
  assign offset    = aliasHit ? {6'h0, reqAddr[ALIAS_LSB-1:0]}
                              : diff[25:0];

endmodule : rom_block_cfg

// ### verilog/rom_flash_interface.sv
// Purpose: processor-side slave driving two ROM/Flash blocks
// Assumes: requests naturally aligned; bursts are 32 bytes, 4 beats of 8
// Notes:   byte 0 is data bits 63:56; upper half carries bytes 0-3
`timescale 1ns/1ps
module rom_flash_interface
  import rom_flash_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [1:0]  strapVec,
  input  wire logic [1:0]  strapWide,
  input  wire logic [1:0]  cfgWrite,
  input  wire logic        cfgEnableIn,
  input  wire logic        cfgWrEnIn,
  input  wire logic        cfgVecEnIn,
  input  wire logic [9:0]  cfgBaseIn,
  input  wire logic [2:0]  cfgSizeIn,
  input  wire logic [3:0]  cfgAccessIn,
  output logic [1:0]       stEnable,
  output logic [1:0]       stWrEn,
  output logic [1:0]       stVecEn,
  output logic [1:0]       stWide,
  output logic [9:0]       stBaseA,
  output logic [9:0]       stBaseB,
  output logic [2:0]       stSizeA,
  output logic [2:0]       stSizeB,
  output logic [3:0]       stAccessA,
  output logic [3:0]       stAccessB,
  input  wire logic        reqValid,
  input  wire logic [31:0] reqAddr,
  input  wire logic        reqWrite,
  input  wire logic [3:0]  reqSize,
  input  wire logic        reqBurst,
  input  wire logic [63:0] reqWdata,
  output logic             reqReady,
  output logic             reqHit,
  output logic             respValid,
  output logic [63:0]      respData,
  output logic [1:0]       romCsN,
  output logic             romOeN,
  output logic             romWeN,
  output logic             romUpperN,
  output logic             romLowerN,
  output logic [22:0]      romAddr,
  input  wire logic [63:0] romDataIn,
  output logic [63:0]      romDataOut,
  output logic             romDataOeN
);

  seq_state_t  state_q;
  logic [1:0]  hitBlk;
  logic [1:0]  aliasBlk;
  logic [1:0]  strapDone;
  logic [25:0] offA;
  logic [25:0] offB;
  logic        selB;
  logic [25:0] startOff;
  logic        selWide;
  logic        selWrEn;
  logic [3:0]  selAccess;
  logic        take;
  logic        wrOk;
  logic        doWrite;
  logic [25:0] off_q;
  logic        blk_q;
  logic        wide_q;
  logic        wr_q;
  logic [5:0]  remain_q;
  logic [4:0]  cnt_q;
  logic [63:0] beat_q;
  logic [63:0] inS1_q;
  logic [63:0] inS2_q;
  logic [22:0] addr_q;
  logic        upper_q;
  logic        lower_q;
  logic [63:0] wdata_q;
  logic        resp_q;
  logic [63:0] respData_q;
  logic [5:0]  step;
  logic [25:0] nextOff;
  logic        lastAcc;
  logic        beatEnd;
  logic [7:0]  rdByte;
  logic [63:0] byteMask;
  logic [63:0] merged;
  logic [5:0]  startRemain;
  logic [25:0] startAligned;
  logic [4:0]  accLoad;

  // per-block configuration and decode
  rom_block_cfg #(.BASE_RST(BASE_A_RST)) blockA (
    .clk         (clk),
    .rst         (rst),
    .strapVec    (strapVec[0]),
    .strapWide   (strapWide[0]),
    .cfgWrite    (cfgWrite[0]),
    .cfgEnableIn (cfgEnableIn),
    .cfgWrEnIn   (cfgWrEnIn),
    .cfgVecEnIn  (cfgVecEnIn),
    .cfgBaseIn   (cfgBaseIn),
    .cfgSizeIn   (cfgSizeIn),
    .cfgAccessIn (cfgAccessIn),
    .reqAddr     (reqAddr),
    .enable_q    (stEnable[0]),
    .wrEn_q      (stWrEn[0]),
    .vecEn_q     (stVecEn[0]),
    .wide_q      (stWide[0]),
    .base_q      (stBaseA),
    .size_q      (stSizeA),
    .access_q    (stAccessA),
    .strapDone_q (strapDone[0]),
    .hit         (hitBlk[0]),
    .aliasHit    (aliasBlk[0]),
    .offset      (offA)
  );

  rom_block_cfg #(.BASE_RST(BASE_B_RST)) blockB (
    .clk         (clk),
    .rst         (rst),
    .strapVec    (strapVec[1]),
    .strapWide   (strapWide[1]),
    .cfgWrite    (cfgWrite[1]),
    .cfgEnableIn (cfgEnableIn),
    .cfgWrEnIn   (cfgWrEnIn),
    .cfgVecEnIn  (cfgVecEnIn),
    .cfgBaseIn   (cfgBaseIn),
    .cfgSizeIn   (cfgSizeIn),
    .cfgAccessIn (cfgAccessIn),
    .reqAddr     (reqAddr),
    .enable_q    (stEnable[1]),
    .wrEn_q      (stWrEn[1]),
    .vecEn_q     (stVecEn[1]),
    .wide_q      (stWide[1]),
    .base_q      (stBaseB),
    .size_q      (stSizeB),
    .access_q    (stAccessB),
    .strapDone_q (strapDone[1]),
    .hit         (hitBlk[1]),
    .aliasHit    (aliasBlk[1]),
    .offset      (offB)
  );

  // block select: an alias hit wins, then block A before block B
  assign selB      = aliasBlk[0] ? 1'b0 :
                     aliasBlk[1] ? 1'b1 : !hitBlk[0];
  assign startOff  = selB ? offB : offA;
  assign selWide   = selB ? stWide[1] : stWide[0];
  assign selWrEn   = selB ? stWrEn[1] : stWrEn[0];
  assign selAccess = selB ? stAccessB : stAccessA;

  // request acceptance
  assign reqReady = (state_q == ST_IDLE) && (&strapDone);
  assign reqHit   = |hitBlk;
  assign take     = reqValid && reqReady && reqHit;

  // write filter; a dropped write still answers so the bus never hangs
  assign wrOk    = selWide ? (reqSize == 4'h4) && (reqAddr[1:0] == 2'h0)
                           : (reqSize == 4'h1);
  assign doWrite = reqWrite && wrOk && selWrEn;

  // transfer length: wide reads move 8 bytes per access
  assign startRemain  = reqBurst ? BURST_BYTES :
                        selWide  ? 6'h08 : {2'h0, reqSize};
  assign startAligned = reqBurst ? (startOff & BURST_MASK[25:0])
                      : selWide  ? {startOff[25:3], 3'h0}
                                 : startOff;
  assign accLoad      = {1'b0, selAccess} + SYNC_LAT;

  // device address from block offset
  function automatic logic [22:0] devAddr(input logic [25:0] off,
                                          input logic        wide);
    devAddr = wide ? off[25:3]
                   : {off[23:3], off[1:0]};
  endfunction : devAddr

  // per-access progress
  assign step    = wide_q ? 6'h08 : 6'h01;
  assign nextOff = off_q + {20'h0, step};
  assign lastAcc = (remain_q == step);
  assign beatEnd = lastAcc || (nextOff[2:0] == 3'h0);

  // read merge; raw pass-through, nothing checked or corrected
  assign rdByte   = off_q[2] ? inS2_q[7:0] : inS2_q[15:8];
  assign byteMask = 64'hff00_0000_0000_0000 >> {off_q[2:0], 3'h0};
  assign merged   = wide_q ? inS2_q
                  : (beat_q & ~byteMask) |
                    ({56'h0, rdByte} << {~off_q[2:0], 3'h0});

  // read data pins are asynchronous to clk: two flops, covered by SYNC_LAT
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      inS1_q <= 64'h0;
      inS2_q <= 64'h0;
    end
    else
    begin
      inS1_q <= romDataIn;
      inS2_q <= inS1_q;
    end
  end

  // sequencer: idle, strobed access, one-cycle recovery gap
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q  <= ST_IDLE;
      cnt_q    <= 5'h0;
      remain_q <= 6'h0;
      off_q    <= 26'h0;
      blk_q    <= 1'b0;
      wide_q   <= 1'b0;
      wr_q     <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (take && (!reqWrite || doWrite))
          begin
            state_q  <= ST_ACCESS;
            cnt_q    <= accLoad;
            remain_q <= startRemain;
            off_q    <= startAligned;
            blk_q    <= selB;
            wide_q   <= selWide;
            wr_q     <= reqWrite;
          end
        end
        ST_ACCESS:
        begin
          if (cnt_q != 5'h0)
            cnt_q <= cnt_q - 5'h1;
          else if (wr_q || lastAcc)
            state_q <= ST_IDLE;
          else
          begin
            state_q  <= ST_GAP;
            remain_q <= remain_q - step;
            off_q    <= nextOff;
          end
        end
        ST_GAP:
        begin
          state_q <= ST_ACCESS;
          cnt_q   <= {1'b0, blk_q ? stAccessB : stAccessA} + SYNC_LAT;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // pin-side address, half selects and write data, set per access
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      addr_q  <= 23'h0;
      upper_q <= 1'b0;
      lower_q <= 1'b0;
      wdata_q <= 64'h0;
    end
    else if (take && (state_q == ST_IDLE))
    begin
      addr_q  <= devAddr(startAligned, selWide);
      upper_q <= selWide ? (!reqWrite || !startOff[2]) : !startAligned[2];
      lower_q <= selWide ? (!reqWrite || startOff[2]) : startAligned[2];
      if (selWide)
        wdata_q <= reqAddr[2] ? {reqWdata[31:0], reqWdata[31:0]}
                              : {reqWdata[63:32], reqWdata[63:32]};
      else
        wdata_q <= {48'h0, {2{reqWdata[63 - {reqAddr[2:0], 3'h0} -: 8]}}};
    end
    else if (state_q == ST_GAP)
    begin
      addr_q  <= devAddr(off_q, wide_q);
      upper_q <= wide_q || !off_q[2];
      lower_q <= wide_q || off_q[2];
    end
  end

  // beat assembly and answer
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      beat_q     <= 64'h0;
      resp_q     <= 1'b0;
      respData_q <= 64'h0;
    end
    else
    begin
      resp_q <= 1'b0;
      if (take && reqWrite && !doWrite)
        resp_q <= 1'b1;
      else if ((state_q == ST_ACCESS) && (cnt_q == 5'h0))
      begin
        if (wr_q)
          resp_q <= 1'b1;
        else
        begin
          beat_q <= merged;
          if (beatEnd)
          begin
            resp_q     <= 1'b1;
            respData_q <= merged;
          end
        end
      end
    end
  end

  // strobes follow the access state; enables already gated at take
  assign romCsN     = (state_q == ST_ACCESS) ? {blk_q, !blk_q} ^ 2'h3
                                             : 2'h3;
  assign romOeN     = !((state_q == ST_ACCESS) && !wr_q);
  assign romWeN     = !((state_q == ST_ACCESS) && wr_q);
  assign romUpperN  = !((state_q == ST_ACCESS) && upper_q);
  assign romLowerN  = !((state_q == ST_ACCESS) && lower_q);
  assign romAddr    = addr_q;
  assign romDataOut = wdata_q;
  assign romDataOeN = !((state_q == ST_ACCESS) && wr_q);
  assign respValid  = resp_q;
  assign respData   = respData_q;

endmodule : rom_flash_interface

// ### dv/rom_flash_interface_chk.sv
// Purpose: port-level assertions for the ROM/Flash interface
// Assumes: one clock domain, rst asynchronous and active high
// Notes:   strobe lengths are measured by small helper counters
`timescale 1ns/1ps
module rom_flash_interface_chk
  import rom_flash_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [1:0]  stEnable,
  input wire logic [1:0]  stWrEn,
  input wire logic [1:0]  stVecEn,
  input wire logic [1:0]  stWide,
  input wire logic [9:0]  stBaseA,
  input wire logic [9:0]  stBaseB,
  input wire logic [2:0]  stSizeA,
  input wire logic [2:0]  stSizeB,
  input wire logic [3:0]  stAccessA,
  input wire logic [3:0]  stAccessB,
  input wire logic        reqValid,
  input wire logic [31:0] reqAddr,
  input wire logic        reqWrite,
  input wire logic        reqReady,
  input wire logic        reqHit,
  input wire logic [1:0]  romCsN,
  input wire logic        romOeN,
  input wire logic        romWeN,
  input wire logic        romUpperN,
  input wire logic        romLowerN,
  input wire logic [22:0] romAddr,
  input wire logic        romDataOeN
);
  logic [4:0]  lowCnt_q;
  logic [3:0]  accLen_q;
  logic [3:0]  upCnt_q;
  logic        strobeLo;
  logic        wSel;
  logic        hitExp;
  logic [31:0] offA;
  logic [31:0] offB;
  // decode expected from the status ports; alias ignores overall enable
  assign strobeLo = !romOeN || !romWeN;
  assign wSel = romCsN[0] ? stWide[1] : stWide[0];
  assign offA = reqAddr - {stBaseA, 22'h0};
  assign offB = reqAddr - {stBaseB, 22'h0};
  assign hitExp = (stEnable[0] && offA < (SIZE_UNIT << stSizeA))
               || (stEnable[1] && offB < (SIZE_UNIT << stSizeB))
               || (reqAddr[31:20] == ALIAS_TAG && stVecEn != 2'h0);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // strobe length, its block's access code, cycles since reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lowCnt_q <= 5'h0;
      accLen_q <= 4'h0;
      upCnt_q  <= 4'h0;
    end
    else
    begin
      lowCnt_q <= strobeLo ? lowCnt_q + 5'h1 : 5'h0;
      if (strobeLo)
        accLen_q <= romCsN[0] ? stAccessB : stAccessA;
      if (upCnt_q != 4'hf)
        upCnt_q <= upCnt_q + 4'h1;
    end
  end
  sequence s_strobe_end;
    strobeLo ##1 !strobeLo;
  endsequence
  a_cs_exclusive: assert property (romCsN != 2'h0)
    else $error("both blocks selected");
  a_write_enabled: assert property (!romWeN |-> (!romCsN[0] && stWrEn[0])
    || (!romCsN[1] && stWrEn[1]))
    else $error("write strobe without write enable");
  a_read_enabled: assert property (!romOeN |->
    (!romCsN[0] && (stEnable[0] || stVecEn[0]))
    || (!romCsN[1] && (stEnable[1] || stVecEn[1])))
    else $error("read strobe on a disabled block");
  a_write_drives: assert property (!romWeN |-> !romDataOeN && romOeN)
    else $error("write strobe without data drive");
  a_access_len: assert property (s_strobe_end |->
    lowCnt_q == {1'b0, accLen_q} + 5'h3)
    else $error("strobe length differs from access time");
  a_width_fixed: assert property (upCnt_q == 4'hf |-> $stable(stWide))
    else $error("width status changed");
  a_narrow_half: assert property (strobeLo && !wSel |->
    romUpperN != romLowerN)
    else $error("narrow access not on one half");
  a_wide_read: assert property (!romOeN && wSel |->
    !romUpperN && !romLowerN)
    else $error("wide read not on both halves");
  a_addr_hold: assert property (strobeLo && $past(strobeLo) |->
    $stable(romAddr))
    else $error("device address moved in a strobe");
  a_busy_ready: assert property (strobeLo |-> !reqReady)
    else $error("ready during device access");
  a_read_decode: assert property (reqValid && !reqWrite |->
    reqHit == hitExp)
    else $error("read decode mismatch");
endmodule : rom_flash_interface_chk

bind rom_flash_interface rom_flash_interface_chk chk (.clk, .rst,
  .stEnable, .stWrEn, .stVecEn, .stWide, .stBaseA, .stBaseB, .stSizeA,
  .stSizeB, .stAccessA, .stAccessB, .reqValid, .reqAddr, .reqWrite,
  .reqReady, .reqHit, .romCsN, .romOeN, .romWeN, .romUpperN, .romLowerN,
  .romAddr, .romDataOeN);

// ### dv/rom_flash_mem.sv
// Purpose: behavioural ROM/Flash devices on both blocks
// Assumes: data pattern is a function of device address and half
// Notes:   released bus shows the complement of its last value
`timescale 1ns/1ps
module rom_flash_mem (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [1:0]  wide,
  input  wire logic [1:0]  romCsN,
  input  wire logic        romOeN,
  input  wire logic        romWeN,
  input  wire logic        romUpperN,
  input  wire logic [22:0] romAddr,
  input  wire logic [63:0] romDataOut,
  output logic [63:0]      romDataIn,
  output logic [15:0]      rdCnt,
  output logic [15:0]      wrCnt,
  output logic [22:0]      wrAddr,
  output logic             wrUp,
  output logic [31:0]      wrData
);
  logic [63:0] last_q;
  logic        oe_q;
  logic        we_q;
  logic        wSel;
  logic        rdOn;
  // lane use follows the selected block's width
  assign wSel = romCsN[0] ? wide[1] : wide[0];
  assign rdOn = !romOeN && romCsN != 2'h3;
  assign romDataIn = !rdOn ? ~last_q : wSel ?
    {{8'h5a, 1'b0, romAddr}, {8'ha5, 1'b0, romAddr}} :
    {48'h0, romAddr[7:0] ^ 8'h5a, romAddr[7:0] ^ 8'ha5};
  // counts accesses and records the latest programming write
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      last_q <= 64'h0;
      oe_q <= 1'b1;
      we_q <= 1'b1;
      rdCnt <= 16'h0;
      wrCnt <= 16'h0;
      wrAddr <= 23'h0;
      wrUp <= 1'b0;
      wrData <= 32'h0;
    end
    else
    begin
      last_q <= romDataIn;
      oe_q <= romOeN;
      we_q <= romWeN;
      if (rdOn && oe_q)
        rdCnt <= rdCnt + 16'h1;
      if (!romWeN && we_q)
      begin
        wrCnt <= wrCnt + 16'h1;
        wrAddr <= romAddr;
        wrUp <= !romUpperN;
        wrData <= wSel ? (romUpperN ? romDataOut[31:0] : romDataOut[63:32])
          : {24'h0, romUpperN ? romDataOut[7:0] : romDataOut[15:8]};
      end
    end
  end
endmodule : rom_flash_mem

// ### dv/rom_flash_interface_tb.sv
// Purpose: self-checking bench for the ROM/Flash interface
// Assumes: block A strapped 16-bit with alias, block B 64-bit
// Notes:   offsets are random from a fixed seed; edges added by hand
`timescale 1ns/1ps
module rom_flash_interface_tb
  import rom_flash_pkg::*;
;
  logic clk, rst, cfgEnableIn, cfgWrEnIn, cfgVecEnIn, reqValid, reqWrite;
  logic reqBurst, reqReady, reqHit, respValid, romOeN, romWeN;
  logic romUpperN, romLowerN, romDataOeN, wrUp;
  logic [1:0] strapVec, strapWide, cfgWrite, stEnable, stWrEn, stVecEn;
  logic [1:0] stWide, romCsN;
  logic [9:0] cfgBaseIn, stBaseA, stBaseB;
  logic [2:0] cfgSizeIn, stSizeA, stSizeB, szA, szB;
  logic [3:0] cfgAccessIn, stAccessA, stAccessB, reqSize;
  logic [31:0] reqAddr, wrData, o;
  logic [63:0] reqWdata, respData, romDataIn, romDataOut, d;
  logic [63:0] beat [4];
  logic [22:0] romAddr, wrAddr;
  logic [15:0] rdCnt, wrCnt;
  int err_count, cmp_count;
  rom_flash_interface dut (.clk, .rst, .strapVec, .strapWide, .cfgWrite,
    .cfgEnableIn, .cfgWrEnIn, .cfgVecEnIn, .cfgBaseIn, .cfgSizeIn,
    .cfgAccessIn, .stEnable, .stWrEn, .stVecEn, .stWide, .stBaseA, .stBaseB,
    .stSizeA, .stSizeB, .stAccessA, .stAccessB, .reqValid, .reqAddr,
    .reqWrite, .reqSize, .reqBurst, .reqWdata, .reqReady, .reqHit,
    .respValid, .respData, .romCsN, .romOeN, .romWeN, .romUpperN,
    .romLowerN, .romAddr, .romDataIn, .romDataOut, .romDataOeN);
  rom_flash_mem mem (.clk, .rst, .wide(strapWide), .romCsN, .romOeN,
    .romWeN, .romUpperN, .romAddr, .romDataOut, .romDataIn, .rdCnt, .wrCnt,
    .wrAddr, .wrUp, .wrData);
  always #2 clk = ~clk;
  task automatic check(input string nm, input logic [63:0] seen,
                       input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim
  task automatic cfg(input logic b, input logic en, input logic we,
    input logic ve, input logic [9:0] ba, input logic [2:0] sz,
    input logic [3:0] ac);
    @(posedge clk);
    #1 {cfgEnableIn, cfgWrEnIn, cfgVecEnIn} = {en, we, ve};
    {cfgBaseIn, cfgSizeIn, cfgAccessIn} = {ba, sz, ac};
    cfgWrite = b ? 2'h2 : 2'h1;
    @(posedge clk);
    #1 cfgWrite = 2'h0;
    check("ctrl", {stEnable[b], stWrEn[b], stVecEn[b]}, {en, we, ve});
    check("base", b ? stBaseB : stBaseA, ba);
    check("size", b ? stSizeB : stSizeA, sz);
    check("access", b ? stAccessB : stAccessA, ac);
    check("width", stWide, strapWide);
  endtask : cfg
  // one request held until taken, then nb answers collected
  task automatic req(input logic [31:0] a, input logic w, input logic [3:0] s,
    input logic bu, input int nb);
    int n;
    int k;
    @(posedge clk);
    #1 {reqValid, reqAddr, reqWrite, reqSize, reqBurst} = {1'b1, a, w, s, bu};
    reqWdata = d;
    #1 n = 0;
    while (!(reqReady === 1'b1 && reqHit === 1'b1) && n < 100)
    begin
      @(posedge clk);
      #2 n++;
    end
    @(posedge clk);
    #1 reqValid = 1'b0;
    k = 0;
    while (k < nb && n < 300)
    begin
      if (respValid === 1'b1)
      begin
        beat[k] = respData;
        k++;
      end
      @(posedge clk);
      #1 n++;
    end
    if (n >= 300)
    begin
      err_count++;
      $display("ERROR wait expected %0d seen %0d", nb, k);
      end_sim();
    end
  endtask : req
  task automatic miss(input logic [31:0] a);
    @(posedge clk);
    #1 {reqValid, reqAddr, reqWrite} = {1'b1, a, 1'b0};
    #1 check("hit", reqHit, 0);
    @(posedge clk);
    #1 reqValid = 1'b0;
    repeat (3) @(posedge clk);
    #1 check("noAnswer", respValid, 0);
  endtask : miss
  function automatic logic [7:0] fb(input logic [31:0] q);
    return {q[8:3], q[1:0]} ^ (q[2] ? 8'ha5 : 8'h5a);
  endfunction : fb
  task automatic rdA(input logic [31:0] a, input logic [31:0] off,
    input logic [3:0] s);
    logic [63:0] e;
    logic [63:0] m;
    logic [15:0] c0;
    logic [31:0] q;
    {e, m, c0} = {128'h0, rdCnt};
    for (int i = 0; i < s; i++)
    begin
      q = off + i;
      e[63 - 8 * q[2:0] -: 8] = fb(q);
      m[63 - 8 * q[2:0] -: 8] = 8'hff;
    end
    req(a + off, 1'b0, s, 1'b0, 1);
    check("narrowData", beat[0] & m, e);
    check("narrowCount", rdCnt - c0, s);
  endtask : rdA
  task automatic rdB(input logic [31:0] a, input logic [31:0] off,
    input logic bu);
    logic [22:0] g;
    logic [15:0] c0;
    c0 = rdCnt;
    g = bu ? {off[25:5], 2'h0} : off[25:3];
    req(a + off, 1'b0, 4'h8, bu, bu ? 4 : 1);
    for (int k = 0; k < (bu ? 4 : 1); k++)
      check("wideData", beat[k], {9'h0b4, g + 23'(k), 9'h14a, g + 23'(k)});
    check("wideCount", rdCnt - c0, bu ? 4 : 1);
  endtask : rdB
  task automatic wr(input logic [31:0] a, input logic [3:0] s, input bit ok,
    input logic [22:0] ea, input logic eu, input logic [31:0] ed);
    logic [15:0] c0;
    c0 = wrCnt;
    req(a, 1'b1, s, 1'b0, 1);
    check("wrCount", wrCnt - c0, ok);
    if (ok)
      check("wrCycle", {wrAddr, wrUp, wrData}, {ea, eu, ed});
  endtask : wr
  initial
  begin
    {clk, rst, strapVec, strapWide, cfgWrite} = {2'b01, 2'h1, 2'h2, 2'h0};
    {cfgEnableIn, cfgWrEnIn, cfgVecEnIn, cfgBaseIn, cfgSizeIn} = 0;
    {cfgAccessIn, reqValid, reqAddr, reqWrite, reqSize, reqBurst} = 0;
    {reqWdata, d, err_count, cmp_count} = 0;
    void'($urandom(40));
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    repeat (6) @(posedge clk);
    #1 check("resetCtrl", {stEnable, stWrEn, stVecEn}, 6'h01);
    check("resetBase", {stBaseA, stBaseB}, 20'hff3fd);
    check("resetSize", {stSizeA, stSizeB, stWide}, 8'h02);
    check("resetAccess", {stAccessA, stAccessB}, 8'hff);
    miss(32'hff000000);
    rdA(32'hfff00000, $urandom % 32'h100000 & ~32'h3, 4'h4);
    {szA, szB} = {3'($urandom % 3), 3'($urandom % 5)};
    cfg(1'b0, 1'b1, 1'b1, 1'b1, 10'h3fc, szA, 4'($urandom % 4));
    cfg(1'b1, 1'b1, 1'b1, 1'b0, 10'h3f0, szB, 4'($urandom % 4));
    rdA(32'hff000000, (32'h100000 << szA) - 1, 4'h1);
    rdB(32'hfc000000, (32'h100000 << szB) - 8, 1'b0);
    repeat (20)
    begin
      o = $urandom;
      if (o[31])
        rdA(32'hff000000, o % (32'h100000 << szA) & ~32'h7, 4'h1 << o[30:29]);
      else
        rdB(32'hfc000000, o % (32'h100000 << szB) & ~32'h7, o[30]);
    end
    d = {$urandom, $urandom};
    o = $urandom % (32'h100000 << szA);
    wr(32'hff000000 + o, 4'h1, 1, {o[23:3], o[1:0]}, !o[2],
      {24'h0, d[63 - 8 * o[2:0] -: 8]});
    wr(32'hff000000, 4'h2, 0, 0, 0, 0);
    o = $urandom % (32'h100000 << szB) & ~32'h3;
    wr(32'hfc000000 + o, 4'h4, 1, o[25:3], !o[2],
      o[2] ? d[31:0] : d[63:32]);
    wr(32'hfc000002, 4'h4, 0, 0, 0, 0);
    wr(32'hfc000000, 4'h8, 0, 0, 0, 0);
    cfg(1'b0, 1'b0, 1'b0, 1'b1, 10'h3fc, szA, 4'h0);
    wr(32'hfff00000, 4'h1, 0, 0, 0, 0);
    miss(32'hff000000);
    rdA(32'hfff00000, 32'h000ffff8, 4'h8);
    cfg(1'b0, 1'b0, 1'b0, 1'b0, 10'h3fc, szA, 4'h0);
    cfg(1'b1, 1'b1, 1'b1, 1'b1, 10'h3f0, szB, 4'hf);
    rdB(32'hfff00000, $urandom % 32'h100000 & ~32'h7, 1'b1);
    miss(32'h10000000);
    end_sim();
  end
endmodule : rom_flash_interface_tb
